/* File: src/fop_pkg.sv */
// Shared constants for the flag offset programmer: codes, preset values, timing.
//
// Operation
// RULE1: Select inputs sampled during master reset choose method
// RULE2: Three methods: preset, parallel, serial load
// RULE3: Preset loads 8, 16, 64, 256 or 1024
// RULE4: Serial mode: select 1 is active-low enable
// RULE5: Enabled clock edge shifts serial data into chain
// RULE6: Serial sequence is 44, 48 or 52 bits
// RULE7: Order: almost-full-1 MSB first, almost-empty-2 LSB last
// RULE8: Disabled edges ignore data, keep offsets unchanged
`default_nettype none

package fop_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int OFFSET_W_DEF = 11;     // Offset width of the smallest variant
	localparam int NUM_OFFSETS  = 4;      // Offset registers in the chain
	localparam int PORT_A_W     = 36;     // Parallel data port width
	localparam int SEL_W        = 3;      // Offset select code width

	// ----------------------------------------
	// Select codes sampled during master reset
	// ----------------------------------------
	localparam logic [2:0] SEL_PRESET_8    = 3'h0;
	localparam logic [2:0] SEL_PRESET_16   = 3'h1;
	localparam logic [2:0] SEL_PRESET_64   = 3'h2;
	localparam logic [2:0] SEL_PRESET_256  = 3'h3;
	localparam logic [2:0] SEL_PRESET_1024 = 3'h4;
	localparam logic [2:0] SEL_PARALLEL    = 3'h5;
	localparam logic [2:0] SEL_SERIAL      = 3'h6;
	localparam logic [2:0] SEL_RESERVED    = 3'h7; // Treated as preset 8

	// ----------------------------------------
	// Preset offset values in words
	// ----------------------------------------
	localparam logic [15:0] PRESET_8    = 16'h0008;
	localparam logic [15:0] PRESET_16   = 16'h0010;
	localparam logic [15:0] PRESET_64   = 16'h0040;
	localparam logic [15:0] PRESET_256  = 16'h0100;
	localparam logic [15:0] PRESET_1024 = 16'h0400;

	// ----------------------------------------
	// Field positions in the chain, counted from the top
	// ----------------------------------------
	localparam int FLD_AF1 = 0;           // Shifted in first
	localparam int FLD_AE1 = 1;
	localparam int FLD_AF2 = 2;
	localparam int FLD_AE2 = 3;           // Shifted in last

	// ----------------------------------------
	// Method reported to the user side
	// ----------------------------------------
	localparam logic [1:0] METH_NONE     = 2'h0;
	localparam logic [1:0] METH_PRESET   = 2'h1;
	localparam logic [1:0] METH_PARALLEL = 2'h2;
	localparam logic [1:0] METH_SERIAL   = 2'h3;

	// ----------------------------------------
	// Host timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;    // 100 MHz reference clock
	localparam int MRST_TIME_NS  = 40;    // Master reset pulse length
	localparam int MRST_CYCLES   = (MRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

`default_nettype wire

/* File: src/fop_link_if.sv */
// Link between the host controller and the offset programming device.
`default_nettype none

interface fop_link_if;

	logic master_reset;             // Master reset, active high
	logic offset_sel0_serial_din;   // Select 0, serial data in serial mode
	logic offset_sel1_serial_en_n;  // Select 1, serial enable low in serial mode
	logic offset_sel_top;           // Select 2

	// Host drives every line
	modport host
	(
		output master_reset,
		output offset_sel0_serial_din,
		output offset_sel1_serial_en_n,
		output offset_sel_top
	);

	// Device only listens
	modport device
	(
		input  master_reset,
		input  offset_sel0_serial_din,
		input  offset_sel1_serial_en_n,
		input  offset_sel_top
	);

endinterface

`default_nettype wire

/* File: src/fop_offset_chain.sv */
// Offset register chain: parallel load or one-bit shift, load has priority.
`default_nettype none

module fop_offset_chain
#(
	parameter int WIDTH = 44                    // Total chain length in bits
)
(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             load_en,      // Replace whole chain
	input  wire logic [WIDTH-1:0] load_val,
	input  wire logic             shift_en,     // Shift one bit in at the bottom
	input  wire logic             din,
	output logic      [WIDTH-1:0] chain_q
);

	// ----------------------------------------
	// Chain storage
	// ----------------------------------------
	// Bits enter at the LSB and move up, so the first bit ends at the MSB
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			chain_q <= '0;
		end
		else if (load_en)
		begin
			chain_q <= load_val;
		end
		else if (shift_en)
		begin
			chain_q <= {chain_q[WIDTH-2:0], din};                   // [RULE5] [RULE7]
		end
		// No strobe: contents held                               // [RULE8]
	end

endmodule

`default_nettype wire

/* File: src/fop_device.sv */
// Device end: samples the select code at master reset and programs the offsets.
//
// The plain strobed parallel port was chosen for this implementation.
`default_nettype none

module fop_device
	import fop_pkg::*;
#(
	parameter int OFFSET_W = fop_pkg::OFFSET_W_DEF      // 11, 12 or 13 bits per offset
)
(
	input  wire logic                         REF_CLK,
	input  wire logic                         RST,
	fop_link_if.device                        LINK,
	input  wire logic [fop_pkg::PORT_A_W-1:0] PAR_DATA,
	input  wire logic                         PAR_WR,
	output logic      [OFFSET_W-1:0]          AF1_OFFSET,
	output logic      [OFFSET_W-1:0]          AE1_OFFSET,
	output logic      [OFFSET_W-1:0]          AF2_OFFSET,
	output logic      [OFFSET_W-1:0]          AE2_OFFSET,
	output logic      [1:0]                   METHOD,
	output logic                              PROG_DONE,
	output logic      [7:0]                   BIT_COUNT
);

	import fop_pkg::*;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int TOTAL = NUM_OFFSETS * OFFSET_W;    // 44, 48 or 52 serial bits

	// ----------------------------------------
	// Types and state
	// ----------------------------------------
	typedef enum logic [2:0]
	{
		ST_IDLE,        // No master reset seen since system reset
		ST_MRST,        // Master reset held, select lines sampled
		ST_SERIAL,      // Collecting serial bits
		ST_PARALLEL,    // Collecting parallel offset writes
		ST_DONE         // Offsets programmed
	} fop_dev_state_type;

	fop_dev_state_type state_q;                    // Programming state
	logic [SEL_W-1:0]  sel_q;                      // Select code caught at master reset
	logic [7:0]        count_q;                    // Bits or words taken so far
	logic [1:0]        method_q;                   // Method in use
	logic              done_q;                     // Programming finished
	logic [TOTAL-1:0]  chain;                      // Offset chain contents
	logic              load_en;                    // Whole chain replaced this cycle
	logic [TOTAL-1:0]  load_val;                   // Value for whole-chain load
	logic              shift_en;                   // One serial bit enters
	logic [SEL_W-1:0]  sel_now;                    // Select lines as seen now
	logic              mrst_end;                   // Master reset released this cycle
	logic              par_take;                   // Parallel word accepted this cycle

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// Preset value for a code; reserved code falls back to the smallest
	function automatic logic [OFFSET_W-1:0] preset_of(input logic [SEL_W-1:0] code);
		logic [15:0] v;
		v = PRESET_8;
		unique case (code)
			SEL_PRESET_16:   v = PRESET_16;
			SEL_PRESET_64:   v = PRESET_64;
			SEL_PRESET_256:  v = PRESET_256;
			SEL_PRESET_1024: v = PRESET_1024;
			default:         v = PRESET_8;
		endcase
		return v[OFFSET_W-1:0];                                  // [RULE3]
	endfunction

	// Chain with one offset field replaced, fields counted from the top
	function automatic logic [TOTAL-1:0] put_field(input logic [TOTAL-1:0] c,
		input logic [7:0] idx, input logic [OFFSET_W-1:0] val);
		logic [TOTAL-1:0] r;
		r = c;
		for (int i = 0; i < NUM_OFFSETS; i++)
		begin
			if (idx == 8'(i))
			begin
				r[TOTAL-1-i*OFFSET_W -: OFFSET_W] = val;
			end
		end
		return r;
	endfunction

	// Field of the chain, counted from the top
	function automatic logic [OFFSET_W-1:0] get_field(input logic [TOTAL-1:0] c,
		input int idx);
		return c[TOTAL-1-idx*OFFSET_W -: OFFSET_W];
	endfunction

	// ----------------------------------------
	// Decode of link events
	// ----------------------------------------
	always_comb
	begin
		sel_now  = {LINK.offset_sel_top, LINK.offset_sel1_serial_en_n,
			LINK.offset_sel0_serial_din};
		mrst_end = (state_q == ST_MRST) && !LINK.master_reset;
		// Only a low enable in serial mode moves the chain      // [RULE4] [RULE8]
		shift_en = (state_q == ST_SERIAL) && !LINK.master_reset
			&& !LINK.offset_sel1_serial_en_n;
		par_take = (state_q == ST_PARALLEL) && !LINK.master_reset && PAR_WR;
	end

	// ----------------------------------------
	// Whole-chain load value
	// ----------------------------------------
	// Preset fills all four offsets alike at master reset release
	always_comb
	begin
		load_en  = 1'b0;
		load_val = chain;
		if (mrst_end && sel_q != SEL_PARALLEL && sel_q != SEL_SERIAL)
		begin
			load_en  = 1'b1;                                         // [RULE3]
			load_val = {NUM_OFFSETS{preset_of(sel_q)}};
		end
		else if (par_take)
		begin
			// One offset per write from the low bits of the port
			load_en  = 1'b1;
			load_val = put_field(chain, count_q, PAR_DATA[OFFSET_W-1:0]);
		end
	end

	// ----------------------------------------
	// Offset chain
	// ----------------------------------------
	fop_offset_chain
	#(
		.WIDTH (TOTAL)
	)
	u_chain
	(
		.clk      (REF_CLK),
		.rst      (RST),
		.load_en  (load_en),
		.load_val (load_val),
		.shift_en (shift_en),
		.din      (LINK.offset_sel0_serial_din),                   // [RULE5]
		.chain_q  (chain)
	);

	// ----------------------------------------
	// Select code capture
	// ----------------------------------------
	// Sampled every cycle of master reset; the last sample counts
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			sel_q <= SEL_PRESET_8;
		end
		else if (LINK.master_reset)
		begin
			sel_q <= sel_now;                                        // [RULE1]
		end
	end

	// ----------------------------------------
	// Programming state machine
	// ----------------------------------------
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			state_q <= ST_IDLE;
		end
		else if (LINK.master_reset)
		begin
			// Master reset restarts programming from any state
			state_q <= ST_MRST;                                      // [RULE1]
		end
		else
		begin
			unique case (state_q)
				ST_IDLE:
				begin
					state_q <= ST_IDLE;
				end
				ST_MRST:
				begin
					// Method chosen from the captured code       // [RULE2]
					if (sel_q == SEL_SERIAL)
					begin
						state_q <= ST_SERIAL;
					end
					else if (sel_q == SEL_PARALLEL)
					begin
						state_q <= ST_PARALLEL;
					end
					else
					begin
						state_q <= ST_DONE;
					end
				end
				ST_SERIAL:
				begin
					// Last of 4*OFFSET_W bits closes the sequence  // [RULE6]
					if (shift_en && count_q == 8'(TOTAL - 1))
					begin
						state_q <= ST_DONE;
					end
				end
				ST_PARALLEL:
				begin
					if (par_take && count_q == 8'(NUM_OFFSETS - 1))
					begin
						state_q <= ST_DONE;
					end
				end
				ST_DONE:
				begin
					state_q <= ST_DONE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Bit and word counter
	// ----------------------------------------
	always_ff @(posedge REF_CLK)
	begin
		if (RST || LINK.master_reset)
		begin
			count_q <= 8'h00;
		end
		else if (shift_en || par_take)
		begin
			count_q <= count_q + 8'h01;                              // [RULE6]
		end
	end

	// ----------------------------------------
	// Method and completion flags
	// ----------------------------------------
	always_ff @(posedge REF_CLK)
	begin
		if (RST || LINK.master_reset)
		begin
			method_q <= METH_NONE;
			done_q   <= 1'b0;
		end
		else if (mrst_end)
		begin
			if (sel_q == SEL_SERIAL)
			begin
				method_q <= METH_SERIAL;
			end
			else if (sel_q == SEL_PARALLEL)
			begin
				method_q <= METH_PARALLEL;
			end
			else
			begin
				method_q <= METH_PRESET;
				done_q   <= 1'b1;                                    // [RULE3]
			end
		end
		else if ((shift_en && count_q == 8'(TOTAL - 1))
			|| (par_take && count_q == 8'(NUM_OFFSETS - 1)))
		begin
			done_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// Outputs, all from flip-flops
	// ----------------------------------------
	assign AF1_OFFSET = get_field(chain, FLD_AF1);                  // [RULE7]
	assign AE1_OFFSET = get_field(chain, FLD_AE1);
	assign AF2_OFFSET = get_field(chain, FLD_AF2);
	assign AE2_OFFSET = get_field(chain, FLD_AE2);
	assign METHOD     = method_q;
	assign PROG_DONE  = done_q;
	assign BIT_COUNT  = count_q;

endmodule

`default_nettype wire

/* File: src/fop_host.sv */
// Host end: pulses master reset with a select code, then sends serial bits when the code selects serial mode.
`default_nettype none

module fop_host
	import fop_pkg::*;
#(
	parameter int OFFSET_W = fop_pkg::OFFSET_W_DEF      // Must match the device
)
(
	input  wire logic                                   REF_CLK,
	input  wire logic                                   RST,
	fop_link_if.host                                    LINK,
	input  wire logic                                   START,
	input  wire logic [fop_pkg::SEL_W-1:0]              METHOD_CODE,
	input  wire logic [fop_pkg::NUM_OFFSETS*OFFSET_W-1:0] SERIAL_WORD,
	output logic                                        BUSY,
	output logic                                        DONE
);

	import fop_pkg::*;

	localparam int TOTAL = NUM_OFFSETS * OFFSET_W;    // Bits in one serial sequence

	typedef enum logic [2:0]
	{
		H_IDLE,     // Waiting for start
		H_MRST,     // Master reset held with select code
		H_GAP,      // One quiet cycle after release
		H_SHIFT,    // Serial bits on the wire
		H_DONE      // Sequence complete
	} fop_host_state_type;

	fop_host_state_type state_q;
	logic [SEL_W-1:0]   code_q;        // Captured method code
	logic [TOTAL-1:0]   word_q;        // Remaining serial bits, MSB next
	logic [7:0]         cnt_q;         // Cycles or bits counted
	logic               mrst_q;        // Drives master reset
	logic               din_q;         // Drives select 0 / serial data
	logic               sen_n_q;       // Drives select 1 / serial enable
	logic               top_q;         // Drives select 2

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			state_q <= H_IDLE;
			code_q  <= SEL_PRESET_8;
			word_q  <= '0;
			cnt_q   <= 8'h00;
			mrst_q  <= 1'b0;
			din_q   <= 1'b0;
			sen_n_q <= 1'b1;
			top_q   <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				H_IDLE, H_DONE:
				begin
					if (START)
					begin
						// Code stands on the selects through master reset  // [RULE1]
						state_q <= H_MRST;
						code_q  <= METHOD_CODE;
						word_q  <= SERIAL_WORD;
						cnt_q   <= 8'h01;
						mrst_q  <= 1'b1;
						{top_q, sen_n_q, din_q} <= METHOD_CODE;
					end
				end
				H_MRST:
				begin
					if (cnt_q == 8'(MRST_CYCLES))
					begin
						// Enable held high so no bit lands during release
						mrst_q  <= 1'b0;
						sen_n_q <= 1'b1;                                      // [RULE8]
						state_q <= (code_q == SEL_SERIAL) ? H_GAP : H_DONE;
					end
					else
					begin
						cnt_q <= cnt_q + 8'h01;
					end
				end
				H_GAP:
				begin
					// First bit is the top of the first almost-full offset  // [RULE7]
					din_q   <= word_q[TOTAL-1];
					word_q  <= {word_q[TOTAL-2:0], 1'b0};
					sen_n_q <= 1'b0;                                          // [RULE4]
					cnt_q   <= 8'h01;
					state_q <= H_SHIFT;
				end
				H_SHIFT:
				begin
					if (cnt_q == 8'(TOTAL))
					begin
						// Exactly TOTAL enabled bits sent                   // [RULE6]
						sen_n_q <= 1'b1;
						state_q <= H_DONE;
					end
					else
					begin
						din_q  <= word_q[TOTAL-1];                            // [RULE5]
						word_q <= {word_q[TOTAL-2:0], 1'b0};
						cnt_q  <= cnt_q + 8'h01;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Outputs, all from flip-flops
	// ----------------------------------------
	assign LINK.master_reset            = mrst_q;
	assign LINK.offset_sel0_serial_din  = din_q;
	assign LINK.offset_sel1_serial_en_n = sen_n_q;
	assign LINK.offset_sel_top          = top_q;

	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			BUSY <= 1'b0;
			DONE <= 1'b0;
		end
		else
		begin
			BUSY <= (state_q == H_MRST) || (state_q == H_GAP)
				|| (state_q == H_SHIFT && cnt_q != 8'(TOTAL))
				|| ((state_q == H_IDLE || state_q == H_DONE) && START);
			DONE <= (state_q == H_SHIFT && cnt_q == 8'(TOTAL))
				|| (state_q == H_MRST && cnt_q == 8'(MRST_CYCLES) && code_q != SEL_SERIAL)
				|| (state_q == H_DONE && !START);
		end
	end

endmodule

`default_nettype wire

/* File: sim/fop_link_asserts.sv */
// Concurrent checks on the host to device offset programming link.
`default_nettype none

module fop_link_asserts
	import fop_pkg::*;
#(
	parameter int OFFSET_W = fop_pkg::OFFSET_W_DEF  // Bits per offset
)
(
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic master_reset,
	input wire logic offset_sel0_serial_din,
	input wire logic offset_sel1_serial_en_n,
	input wire logic offset_sel_top
);

	// ----------------------------------------
	// Helper state
	// ----------------------------------------
	localparam int TOTAL = 4 * OFFSET_W;  // Bits in one serial sequence

	logic [2:0] code_q;  // Code seen at the last master reset
	logic [7:0] cnt_q;   // Enabled bits since then
	logic       ser;     // Serial mode, out of master reset

	assign ser = (code_q == SEL_SERIAL) && !master_reset;

	// Capture the select code while master reset is high
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
			code_q <= 3'h0;
		else if (master_reset)
			code_q <= {offset_sel_top, offset_sel1_serial_en_n, offset_sel0_serial_din};
	end

	// Count enabled edges; saturates so a runaway host cannot wrap it
	always_ff @(posedge REF_CLK)
	begin
		if (RST || master_reset)
			cnt_q <= 8'h00;
		else if (ser && !offset_sel1_serial_en_n && cnt_q != 8'hff)
			cnt_q <= cnt_q + 8'h01;
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	reset_idle_a: assert property ($fell(RST) |-> !master_reset && offset_sel1_serial_en_n
		&& !offset_sel0_serial_din && !offset_sel_top) else $error("link not idle after reset");
	mrst_len_a: assert property ($rose(master_reset) |-> master_reset [*4] ##1 !master_reset)
		else $error("master reset length wrong");
	sel_hold_a: assert property (master_reset && $past(master_reset) |-> $stable(
		{offset_sel_top, offset_sel1_serial_en_n, offset_sel0_serial_din}))
		else $error("select moved during master reset");
	// Release edge must be quiet; the device takes bits from the next edge on
	release_gap_a: assert property ($fell(master_reset) && code_q == SEL_SERIAL
		|-> offset_sel1_serial_en_n ##1 !offset_sel1_serial_en_n)
		else $error("no gap at release");
	burst_start_a: assert property (ser && $fell(offset_sel1_serial_en_n)
		|-> cnt_q == 8'h00 ##1 !offset_sel1_serial_en_n [*7]) else $error("serial burst broken");
	bit_total_a: assert property (ser && $rose(offset_sel1_serial_en_n) |-> cnt_q == TOTAL)
		else $error("serial bit count wrong");
	count_cap_a: assert property (cnt_q <= TOTAL) else $error("too many serial bits");
	quiet_after_a: assert property (ser && cnt_q == TOTAL |-> offset_sel1_serial_en_n)
		else $error("enable low after last bit");

endmodule

`default_nettype wire

/* File: sim/tb_flag_offset_programmer.sv */
// Bench: host and device joined, plus a second device fed by an irregular host.
`default_nettype none

module tb_flag_offset_programmer;
	timeunit 1ns;
	timeprecision 1ps;
	import fop_pkg::*;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam int W = 12;  // Middle variant, 48-bit chain
	localparam int T = 4 * W;
	localparam logic [2:0] cl [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};  // Preset codes
	localparam logic [15:0] pv [8] = '{PRESET_8, PRESET_16, PRESET_64, PRESET_256,
		PRESET_1024, PRESET_8, PRESET_8, PRESET_8};
	localparam logic [T-1:0] sw [2] = '{48'hc35_a17_e08_f63, 48'h3ca_5e8_1f7_09c};

	logic         clk = 1'b0;
	logic         rst = 1'b1;
	logic         start = 1'b0;
	logic [2:0]   code = 3'h0;
	logic [T-1:0] word = '0;
	logic [35:0]  pdata = 36'h0;
	logic         pwr = 1'b0;
	logic         b_mr = 1'b0;     // Second link, driven by hand
	logic         b_sen_n = 1'b1;
	logic         b_din = 1'b0;
	logic         b_top = 1'b0;
	int           fail_count = 0;
	int           num_checks = 0;
	int           cycles = 0;
	wire logic         busy, done;
	wire logic [W-1:0] offs [2][4];  // AF1, AE1, AF2, AE2 of each device
	wire logic [1:0]   meth [2];
	wire logic [7:0]   bcnt [2];
	wire logic         pd [2];

	fop_link_if u_fop_link_if ();
	fop_link_if u_fop_link_if_b ();
	assign u_fop_link_if_b.master_reset = b_mr;
	assign u_fop_link_if_b.offset_sel1_serial_en_n = b_sen_n;
	assign u_fop_link_if_b.offset_sel0_serial_din = b_din;
	assign u_fop_link_if_b.offset_sel_top = b_top;

	// ----------------------------------------
	// Instances
	// ----------------------------------------
	fop_host #(.OFFSET_W(W)) u_fop_host
	(
		.REF_CLK     (clk),
		.RST         (rst),
		.LINK        (u_fop_link_if.host),
		.START       (start),
		.METHOD_CODE (code),
		.SERIAL_WORD (word),
		.BUSY        (busy),
		.DONE        (done)
	);

	fop_device #(.OFFSET_W(W)) u_fop_device
	(
		.REF_CLK    (clk),
		.RST        (rst),
		.LINK       (u_fop_link_if.device),
		.PAR_DATA   (pdata),
		.PAR_WR     (pwr),
		.AF1_OFFSET (offs[0][0]),
		.AE1_OFFSET (offs[0][1]),
		.AF2_OFFSET (offs[0][2]),
		.AE2_OFFSET (offs[0][3]),
		.METHOD     (meth[0]),
		.PROG_DONE  (pd[0]),
		.BIT_COUNT  (bcnt[0])
	);

	// Parallel port tied off: this copy only sees serial traffic
	fop_device #(.OFFSET_W(W)) u_fop_device_b
	(
		.REF_CLK    (clk),
		.RST        (rst),
		.LINK       (u_fop_link_if_b.device),
		.PAR_DATA   (36'h0),
		.PAR_WR     (1'b0),
		.AF1_OFFSET (offs[1][0]),
		.AE1_OFFSET (offs[1][1]),
		.AF2_OFFSET (offs[1][2]),
		.AE2_OFFSET (offs[1][3]),
		.METHOD     (meth[1]),
		.PROG_DONE  (pd[1]),
		.BIT_COUNT  (bcnt[1])
	);

	fop_link_asserts #(.OFFSET_W(W)) u_fop_link_asserts
	(
		.REF_CLK                 (clk),
		.RST                     (rst),
		.master_reset            (u_fop_link_if.master_reset),
		.offset_sel0_serial_din  (u_fop_link_if.offset_sel0_serial_din),
		.offset_sel1_serial_en_n (u_fop_link_if.offset_sel1_serial_en_n),
		.offset_sel_top          (u_fop_link_if.offset_sel_top)
	);

	// ----------------------------------------
	// Clock, watchdog, tasks
	// ----------------------------------------
	always #5 clk = ~clk;

	// Whole run needs well under 2000 cycles
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 6000)
		begin
			fail_count++;
			complete_run();
		end
	end

	task automatic complete_run();
		if (fail_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	// All four offsets of one device against a packed chain image
	task automatic chk_offs(input int d, input logic [T-1:0] e);
		for (int i = 0; i < 4; i++)
			cmp(offs[d][i], e[(3-i)*W +: W]);
	endtask

	// One host run; BUSY is checked two cycles after start drops, then DONE is polled
	task automatic run_host(input logic [2:0] c, input logic [T-1:0] w);
		int n;
		n = 0;
		@(posedge clk);
		start <= 1'b1;
		code <= c;
		word <= w;
		@(posedge clk);
		start <= 1'b0;
		repeat (2) @(posedge clk);
		cmp(busy, 1'b1);
		while (done !== 1'b1 && n < 200)
		begin
			@(posedge clk);
			n++;
		end
		cmp(n < 200, 1'b1);
		repeat (2) @(posedge clk);
		// Host settled: busy dropped, done still standing
		cmp(busy, 1'b0);
		cmp(done, 1'b1);
	endtask

	// Back-to-back parallel writes; upper bits carry junk that must be dropped
	task automatic par_wr(input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk);
			pwr <= 1'b1;
			pdata <= {24'h5a5a5a, 12'(7 + 13 * i)};
		end
		@(posedge clk);
		pwr <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	// One enabled bit, then some disabled cycles showing the inverse on data
	task automatic b_bit(input logic b, input int gaps);
		@(posedge clk);
		b_sen_n <= 1'b0;
		b_din <= b;
		repeat (gaps)
		begin
			@(posedge clk);
			b_sen_n <= 1'b1;
			b_din <= ~b;
		end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		foreach (cl[i])
		begin
			run_host(cl[i], '0);
			cmp(meth[0], METH_PRESET);
			cmp(pd[0], 1'b1);
			chk_offs(0, {4{pv[cl[i]][W-1:0]}});
		end
		par_wr(1);
		chk_offs(0, {4{PRESET_8[W-1:0]}});
		run_host(SEL_PARALLEL, '0);
		cmp(meth[0], METH_PARALLEL);
		cmp(pd[0], 1'b0);
		par_wr(5);
		chk_offs(0, {12'h007, 12'h014, 12'h021, 12'h02e});
		cmp(pd[0], 1'b1);
		cmp(bcnt[0], 8'h04);
		foreach (sw[i])
		begin
			run_host(SEL_SERIAL, sw[i]);
			cmp(meth[0], METH_SERIAL);
			cmp(pd[0], 1'b1);
			cmp(bcnt[0], 8'(T));
			chk_offs(0, sw[i]);
		end
		par_wr(1);
		chk_offs(0, sw[1]);
		// Irregular host: bit at the release edge, gaps, extra bits at the end
		@(posedge clk);
		{b_mr, b_top, b_sen_n, b_din} <= 4'he;
		repeat (4) @(posedge clk);
		{b_mr, b_sen_n, b_din} <= 3'b001;
		@(posedge clk);
		b_sen_n <= 1'b1;
		for (int i = T - 1; i >= 0; i--)
			b_bit(sw[0][i], i % 3);
		for (int i = 0; i < 3; i++)
			b_bit(1'b1, 1);
		repeat (3) @(posedge clk);
		chk_offs(1, sw[0]);
		cmp(meth[1], METH_SERIAL);
		cmp(bcnt[1], 8'(T));
		cmp(pd[1], 1'b1);
		complete_run();
	end

endmodule

`default_nettype wire
